// File: dma_seq.sv
`timescale 1ns/100ps
// Overview of operation
// - cycle type from control word bits 2:0
// - 000 idles; finished cycle rewritten as invalid
// - basic needs one request per transfer
// - basic: transfer, arbitrate, resume on request
// - basic count exhausted raises channel done
// - autorequest finishes whole cycle from one request
// - auto bursts min(2^exponent, count) then rearbitrates
// - ping-pong alternates structures until invalid read
// - ping-pong halves act basic, each interrupts
// - memory gather: four primary, then auto alternate
// - memory gather rearbitrates, needs single request
// - gather stops on basic, auto or invalid alternate
// - peripheral gather: four primary, alternate immediately
// - peripheral gather repeats only on own request
// - source address from end pointer and count
// - destination address from end pointer and count
// - count written back before arbitrating
// - count field holds transfers minus one
module dma_seq
  import dma_seq_pkg::*;
(
  // system
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // peripheral requests and completion
  input  wire logic [NUM_CH-1:0] dma_req_i,
  output logic      [NUM_CH-1:0] done_o,
  // memory master
  output logic                   mem_req_o,
  output logic                   mem_we_o,
  output logic      [31:0]       mem_addr_o,
  output logic      [31:0]       mem_wdata_o,
  output logic      [3:0]        mem_sel_o,
  input  wire logic [31:0]       mem_rdata_i,
  input  wire logic              mem_ack_i
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] xfer_addr(input logic [31:0] endp,
                                             input logic [9:0]  cnt,
                                             input logic [1:0]  inc);
    logic [31:0] step;
    step = {22'h0, cnt} << inc;
    xfer_addr = (inc == INC_FIXED) ? endp : endp - step;
  endfunction

  function automatic logic [10:0] burst_len(input logic [3:0] rp, input logic [9:0] cnt);
    logic [10:0] total;
    logic [10:0] pw;
    total = {1'b0, cnt} + 11'h001;
    pw    = (rp > 4'd10) ? 11'h400 : (11'h001 << rp);
    burst_len = (pw < total) ? pw : total;
  endfunction

  function automatic logic [31:0] desc_addr(input logic [31:0] base, input logic [1:0] ch,
                                             input logic alt, input logic [31:0] ofs);
    desc_addr = base + (alt ? ALT_OFFSET : 32'h0) + ({30'h0, ch} * DESC_STRIDE) + ofs;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    seq_state_t        st;
    logic [1:0]        ch;
    logic [9:0]        cnt;
    logic [10:0]       burst;
    logic [31:0]       ctl, src, dst, base, rdat, maddr, mwdat;
    logic [NUM_CH-1:0] pend, altsel, req_s1, req_s2, req_s3, chen, done;
    logic              alt, fin, en, ack, mreq, mwe;
  } state_t;

  state_t s_reg;
  state_t s_next;

  cycle_type_t ctype;
  logic [1:0]  sinc;
  logic [1:0]  dinc;
  logic        wb_hit;
  logic [NUM_CH-1:0] ready;

  assign ctype = cycle_type_t'(s_reg.ctl[TYPE_LSB +: 3]);
  assign sinc  = s_reg.ctl[SINC_LSB +: 2];
  assign dinc  = s_reg.ctl[DINC_LSB +: 2];
  assign wb_hit = wb_cyc_i & wb_stb_i & ~s_reg.ack;
  assign ready  = s_reg.pend & s_reg.chen & {NUM_CH{s_reg.en}};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.done = '0;
    s_next.ack  = wb_hit;
    s_next.req_s1 = dma_req_i;
    s_next.req_s2 = s_reg.req_s1;
    s_next.req_s3 = s_reg.req_s2;
    // register bus; unmapped reads return zero
    if (wb_hit) begin
      case (wb_adr_i)
        REG_CTRL:   s_next.rdat = {31'h0, s_reg.en};
        REG_BASE:   s_next.rdat = s_reg.base;
        REG_CHEN:   s_next.rdat = {28'h0, s_reg.chen};
        REG_ALT:    s_next.rdat = {28'h0, s_reg.altsel};
        REG_STATUS: s_next.rdat = {24'h0, s_reg.pend, 2'h0, s_reg.ch};
        default:    s_next.rdat = 32'h0;
      endcase
      s_next.rdat[31:28] = (wb_adr_i == REG_STATUS) ? s_reg.st : s_next.rdat[31:28];
      if (wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          REG_CTRL: s_next.en = wb_dat_i[0];
          REG_BASE: s_next.base = wb_dat_i;
          REG_CHEN: s_next.chen = wb_dat_i[NUM_CH-1:0];
          REG_ALT:  s_next.altsel = wb_dat_i[NUM_CH-1:0];
          default: begin
          end
        endcase
      end
    end
    case (s_reg.st)
      S_IDLE: begin
        // lowest index wins arbitration
        for (int i = NUM_CH - 1; i >= 0; i--) begin
          if (ready[i]) begin
            s_next.ch = i[1:0];
          end
        end
        if (ready != '0) begin
          s_next.pend[s_next.ch] = 1'b0;
          s_next.alt   = s_reg.altsel[s_next.ch];
          s_next.st    = S_RD_CTL;
          s_next.mreq  = 1'b1;
          s_next.mwe   = 1'b0;
          s_next.maddr = desc_addr(s_reg.base, s_next.ch, s_next.alt, OFS_CTL);
        end
      end
      S_RD_CTL: begin
        if (mem_ack_i) begin
          s_next.ctl = mem_rdata_i;
          s_next.cnt = mem_rdata_i[CNT_LSB +: 10];
          if (mem_rdata_i[TYPE_LSB +: 3] == CT_INVALID) begin
            s_next.mreq = 1'b0;
            s_next.st   = S_IDLE;
          end else begin
            case (cycle_type_t'(mem_rdata_i[TYPE_LSB +: 3]))
              CT_AUTO, CT_MSG_ALT: s_next.burst =
                burst_len(mem_rdata_i[RP_LSB +: 4], mem_rdata_i[CNT_LSB +: 10]);
              CT_MSG_PRI, CT_PSG_PRI: s_next.burst = SG_BURST;
              default: s_next.burst = 11'h001;
            endcase
            s_next.st    = S_RD_SRC;
            s_next.maddr = desc_addr(s_reg.base, s_reg.ch, s_reg.alt, OFS_SRC);
          end
        end
      end
      S_RD_SRC: begin
        if (mem_ack_i) begin
          s_next.src   = mem_rdata_i;
          s_next.st    = S_RD_DST;
          s_next.maddr = desc_addr(s_reg.base, s_reg.ch, s_reg.alt, OFS_DST);
        end
      end
      S_RD_DST: begin
        if (mem_ack_i) begin
          s_next.dst   = mem_rdata_i;
          s_next.st    = S_RD_DATA;
          s_next.maddr = xfer_addr(s_reg.src, s_reg.cnt, sinc);
        end
      end
      S_RD_DATA: begin
        if (mem_ack_i) begin
          s_next.st    = S_WR_DATA;
          s_next.mwe   = 1'b1;
          s_next.mwdat = mem_rdata_i;
          s_next.maddr = xfer_addr(s_reg.dst, s_reg.cnt, dinc);
        end
      end
      S_WR_DATA: begin
        if (mem_ack_i) begin
          s_next.burst = s_reg.burst - 11'h001;
          s_next.fin   = (s_reg.cnt == 10'h0);
          if (s_reg.cnt != 10'h0 && s_reg.burst != 11'h001) begin
            // burst continues with no rearbitration
            s_next.cnt   = s_reg.cnt - 10'h001;
            s_next.st    = S_RD_DATA;
            s_next.mwe   = 1'b0;
            s_next.maddr = xfer_addr(s_reg.src, s_reg.cnt - 10'h001, sinc);
          end else begin
            // count written back before giving up the bus
            s_next.cnt   = (s_reg.cnt == 10'h0) ? 10'h0 : s_reg.cnt - 10'h001;
            s_next.st    = S_WR_CTL;
            s_next.maddr = desc_addr(s_reg.base, s_reg.ch, s_reg.alt, OFS_CTL);
            s_next.mwdat = {s_reg.ctl[31:14], s_next.cnt, s_reg.ctl[3],
                            s_next.fin ? CT_INVALID : s_reg.ctl[2:0]};
          end
        end
      end
      S_WR_CTL: begin
        if (mem_ack_i) begin
          s_next.mreq = 1'b0;
          s_next.mwe  = 1'b0;
          s_next.st   = S_IDLE;
          case (ctype)
            CT_AUTO, CT_MSG_ALT: begin
              if (!s_reg.fin) begin
                s_next.pend[s_reg.ch] = 1'b1;
              end else if (ctype == CT_MSG_ALT) begin
                s_next.altsel[s_reg.ch] = 1'b0;
                s_next.pend[s_reg.ch]   = 1'b1;
              end else begin
                s_next.done[s_reg.ch] = 1'b1;
              end
            end
            CT_MSG_PRI: begin
              s_next.altsel[s_reg.ch] = 1'b1;
              s_next.pend[s_reg.ch]   = 1'b1;
            end
            CT_PSG_PRI: begin
              // alternate starts at once, no arbitration
              s_next.altsel[s_reg.ch] = 1'b1;
              s_next.alt   = 1'b1;
              s_next.mreq  = 1'b1;
              s_next.st    = S_RD_CTL;
              s_next.maddr = desc_addr(s_reg.base, s_reg.ch, 1'b1, OFS_CTL);
            end
            CT_PSG_ALT: begin
              if (s_reg.fin) begin
                s_next.altsel[s_reg.ch] = 1'b0;
              end
            end
            CT_PINGPNG: begin
              if (s_reg.fin) begin
                s_next.done[s_reg.ch]   = 1'b1;
                s_next.altsel[s_reg.ch] = ~s_reg.alt;
              end
            end
            default: begin
              if (s_reg.fin) begin
                s_next.done[s_reg.ch] = 1'b1;
              end
            end
          endcase
        end
      end
      default: begin
        s_next.st   = S_IDLE;
        s_next.mreq = 1'b0;
      end
    endcase
    // new requests win over the clear at take
    s_next.pend = s_next.pend | (s_reg.req_s2 & ~s_reg.req_s3);
    if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_SWREQ) begin
      s_next.pend = s_next.pend | wb_dat_i[NUM_CH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o    = s_reg.ack;
  assign wb_dat_o    = s_reg.rdat;
  assign done_o      = s_reg.done;
  assign mem_req_o   = s_reg.mreq;
  assign mem_we_o    = s_reg.mwe;
  assign mem_addr_o  = s_reg.maddr;
  assign mem_wdata_o = s_reg.mwdat;
  // word-wide only; narrow sizes not lane-steered
  assign mem_sel_o   = 4'hf;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_ctl_read_invalid;
    s_reg.st == S_RD_CTL && mem_ack_i && mem_rdata_i[2:0] == 3'b000;
  endsequence

  sequence s_ctl_written;
    s_reg.st == S_WR_CTL && mem_ack_i;
  endsequence

  property p_invalid_stop;
    @(posedge clk_i) disable iff (rst_i) s_ctl_read_invalid |=> s_reg.st == S_IDLE && !mem_req_o;
  endproperty
  a_invalid_stop: assert property (p_invalid_stop) else $error("invalid structure ran on");

  property p_fin_invalid;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.st == S_WR_CTL && s_reg.fin |-> mem_wdata_o[2:0] == 3'b000;
  endproperty
  a_fin_invalid: assert property (p_fin_invalid) else $error("finished cycle not invalid");

  property p_done_pulse;
    @(posedge clk_i) disable iff (rst_i) done_o != '0 |=> done_o == '0;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

  property p_src_addr;
    @(posedge clk_i) disable iff (rst_i) s_reg.st == S_RD_DATA |->
      mem_addr_o == ((sinc == 2'h3) ? s_reg.src : s_reg.src - ({22'h0, s_reg.cnt} << sinc));
  endproperty
  a_src_addr: assert property (p_src_addr) else $error("bad source address");

  property p_dst_addr;
    @(posedge clk_i) disable iff (rst_i) s_reg.st == S_WR_DATA |->
      mem_addr_o == ((dinc == 2'h3) ? s_reg.dst : s_reg.dst - ({22'h0, s_reg.cnt} << dinc));
  endproperty
  a_dst_addr: assert property (p_dst_addr) else $error("bad destination address");

  property p_writeback_cnt;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.st == S_WR_CTL |-> mem_we_o && mem_wdata_o[13:4] == s_reg.cnt;
  endproperty
  a_writeback_cnt: assert property (p_writeback_cnt) else $error("count not written back");

  property p_basic_single;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.st == S_WR_DATA && mem_ack_i && ctype == CT_BASIC |=> s_reg.st == S_WR_CTL;
  endproperty
  a_basic_single: assert property (p_basic_single) else $error("basic did two transfers");

  property p_sg_four;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.st == S_RD_SRC && (ctype == CT_MSG_PRI || ctype == CT_PSG_PRI) |-> s_reg.burst == 11'h004;
  endproperty
  a_sg_four: assert property (p_sg_four) else $error("gather primary not four");

  property p_psg_immediate;
    @(posedge clk_i) disable iff (rst_i)
      s_ctl_written ##0 ctype == CT_PSG_PRI |=> s_reg.st == S_RD_CTL && s_reg.alt ##1 mem_req_o;
  endproperty
  a_psg_immediate: assert property (p_psg_immediate) else $error("alternate not immediate");

  property p_auto_cap;
    @(posedge clk_i) disable iff (rst_i)
      s_reg.st == S_RD_SRC && ctype == CT_AUTO |->
      s_reg.burst <= {1'b0, s_reg.cnt} + 11'h001 && s_reg.burst != 11'h000;
  endproperty
  a_auto_cap: assert property (p_auto_cap) else $error("auto burst beyond count");

endmodule

// File: dma_seq_pkg.sv
package dma_seq_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int          NUM_CH      = 4;
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
  localparam logic [31:0] ALT_OFFSET  = 32'h0000_0040;
  localparam logic [31:0] OFS_SRC     = 32'h0000_0000;
  localparam logic [31:0] OFS_DST     = 32'h0000_0004;
  localparam logic [31:0] OFS_CTL     = 32'h0000_0008;

  // ----------------------------------------------------------------
  // channel control word fields
  // ----------------------------------------------------------------
  localparam int TYPE_LSB = 0;
  localparam int CNT_LSB  = 4;
  localparam int RP_LSB   = 14;
  localparam int SINC_LSB = 26;
  localparam int DINC_LSB = 30;
  localparam logic [1:0] INC_FIXED = 2'h3;
  localparam logic [10:0] SG_BURST = 11'h004;

  typedef enum logic [2:0] {
    CT_INVALID = 3'b000,
    CT_BASIC   = 3'b001,
    CT_AUTO    = 3'b010,
    CT_PINGPNG = 3'b011,
    CT_MSG_PRI = 3'b100,
    CT_MSG_ALT = 3'b101,
    CT_PSG_PRI = 3'b110,
    CT_PSG_ALT = 3'b111
  } cycle_type_t;

  typedef enum logic [3:0] {
    S_IDLE    = 4'b0000,
    S_RD_CTL  = 4'b0001,
    S_RD_SRC  = 4'b0010,
    S_RD_DST  = 4'b0011,
    S_RD_DATA = 4'b0100,
    S_WR_DATA = 4'b0101,
    S_WR_CTL  = 4'b0111
  } seq_state_t;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_BASE   = 8'h04;
  localparam logic [7:0] REG_CHEN   = 8'h08;
  localparam logic [7:0] REG_SWREQ  = 8'h0c;
  localparam logic [7:0] REG_ALT    = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [31:0] BASE_RST  = 32'h0000_0000;

endpackage

// File: mem_model.sv
`timescale 1ns/100ps
module mem_model (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // memory slave side
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [2:0]  delay_i,
  output logic      [31:0] rdata_o,
  output logic             ack_o
);
  // ----------------------------------------------------------------
  // word storage, unwritten words read as zero
  // ----------------------------------------------------------------
  logic [31:0] mem [logic [29:0]];
  logic [2:0]  wait_reg;

  // ----------------------------------------------------------------
  // answer after a random wait of zero to seven cycles
  // ----------------------------------------------------------------
  // data bus toggles while not acking so stale data never looks valid
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o    <= 1'b0;
      wait_reg <= 3'h0;
      rdata_o  <= 32'h0;
    end else if (ack_o || !req_i) begin
      ack_o    <= 1'b0;
      wait_reg <= delay_i;
      rdata_o  <= ~rdata_o;
    end else if (wait_reg != 3'h0) begin
      wait_reg <= wait_reg - 3'h1;
      rdata_o  <= ~rdata_o;
    end else begin
      ack_o <= 1'b1;
      if (we_i) begin
        mem[addr_i[31:2]] = wdata_i;
      end else begin
        rdata_o <= mem.exists(addr_i[31:2]) ? mem[addr_i[31:2]] : 32'h0;
      end
    end
  end
endmodule

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import dma_seq_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, mem_addr_o, mem_wdata_o, mem_rdata_i, rd;
  logic wb_ack_o, mem_req_o, mem_we_o, mem_ack_i;
  logic [NUM_CH-1:0] dma_req_i = 4'h0, done_o;
  logic [3:0] mem_sel_o;
  logic [2:0] mem_delay = 3'h0;
  logic [31:0] rnd = 32'h4e5f;
  logic [31:0] src [8];
  int errors = 0, check_count = 0, data_wr = 0, ctl_wr = 0, done_cnt [4] = '{0, 0, 0, 0};

  always #4 clk_i = ~clk_i;

  dma_seq dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dma_req_i(dma_req_i), .done_o(done_o),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_sel_o(mem_sel_o), .mem_rdata_i(mem_rdata_i),
    .mem_ack_i(mem_ack_i));
  mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .delay_i(mem_delay), .rdata_o(mem_rdata_i),
    .ack_o(mem_ack_i));

  // ----------------------------------------------------------------
  // random source and monitors
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_addr(input logic [31:0] e, input logic [9:0] n,
                                           input logic [1:0] inc);
    return (inc == 2'h3) ? e : e - ({22'h0, n} << inc);
  endfunction
  always @(posedge clk_i) begin
    rnd       <= lfsr(rnd);
    mem_delay <= rnd[2:0];
    for (int c = 0; c < 4; c++) if (done_o[c] === 1'b1) done_cnt[c]++;
    if (mem_req_o === 1'b1 && mem_ack_i === 1'b1 && mem_we_o === 1'b1) begin
      if (mem_addr_o < 32'h2000) ctl_wr++;
      else data_wr++;
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("errors %0d, comparisons %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
      errors++;
    end
  endtask
  task automatic timeout(input string msg);
    $display("mismatch at %0t: timeout %s", $time, msg);
    errors++;
    report_and_stop();
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= adr; wb_dat_i <= dat;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) begin
      if (++n > 20) timeout("wishbone");
      @(posedge clk_i);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic set_desc(input int ch, input logic [31:0] rgn, input logic [31:0] ctl,
                          input logic [31:0] se, input logic [31:0] de);
    logic [31:0] d;
    d = 32'h1000 + rgn + ch * DESC_STRIDE;
    mem_u.mem[d[31:2]] = se;
    mem_u.mem[d[31:2] + 1] = de;
    mem_u.mem[d[31:2] + 2] = ctl;
  endtask
  // a rising request edge, then wait for that service to finish
  task automatic periph_req(input int ch);
    int n;
    n = 0;
    dma_req_i[ch] <= 1'b1;
    repeat (6) @(posedge clk_i);
    dma_req_i[ch] <= 1'b0;
    while (mem_req_o !== 1'b0 || n < 4) begin
      if (mem_req_o === 1'b1) n = 4;
      if (++n > 3000) timeout("service");
      @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] c;
    int n;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) src[i] = lfsr(rnd ^ i);
    for (int i = 0; i < 8; i++) mem_u.mem[30'h800 + i] = src[i];
    wb(1'b1, REG_CTRL, 32'h1);
    wb(1'b1, REG_BASE, 32'h1000);
    wb(1'b1, REG_CHEN, 32'hf);
    wb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0, "unmapped read");
    check({28'h0, mem_sel_o}, 32'hf, "word lanes");
    // basic, three transfers, word steps
    set_desc(0, 0, 32'haa00_0021, 32'h2008, 32'h3008);
    periph_req(0);
    check(data_wr, 1, "one transfer per request");
    c = mem_u.mem[30'h402];
    check(c[13:0], 14'h0011, "count written back");
    periph_req(0);
    periph_req(0);
    check(data_wr, 3, "basic transfers");
    check(done_cnt[0], 1, "basic done");
    c = mem_u.mem[30'h402];
    check(c[13:0], 14'h0, "finished rewritten invalid");
    for (int i = 0; i < 3; i++)
      check(mem_u.mem[exp_addr(32'h3008, 10'(2 - i), 2'h2) >> 2], src[i], "basic dst");
    // autorequest on alternate, five transfers, bursts of two, fixed dst
    set_desc(1, ALT_OFFSET, 32'he800_4042, 32'h2010, 32'h3100);
    data_wr = 0;
    ctl_wr = 0;
    wb(1'b1, REG_ALT, 32'h2);
    wb(1'b1, REG_SWREQ, 32'h2);
    n = 0;
    while (done_cnt[1] == 0) begin
      if (++n > 3000) timeout("autorequest");
      @(posedge clk_i);
    end
    check(data_wr, 5, "auto single request");
    check(ctl_wr, 3, "auto bursts");
    check(mem_u.mem[exp_addr(32'h3100, 10'h0, 2'h3) >> 2], src[4], "fixed dst");
    // invalid structure starts nothing
    set_desc(2, 0, 32'haa00_0020, 32'h2000, 32'h3200);
    data_wr = 0;
    wb(1'b1, REG_SWREQ, 32'h4);
    repeat (60) @(posedge clk_i);
    check(data_wr, 0, "invalid no transfer");
    check(done_cnt[2], 0, "invalid no done");
    // ping-pong on channel 0, alternate left invalid
    set_desc(0, 0, 32'haa00_0003, 32'h200c, 32'h3500);
    periph_req(0);
    check(done_cnt[0], 2, "ping-pong primary done");
    check(mem_u.mem[30'hd40], src[3], "ping-pong data");
    wb(1'b0, REG_ALT, 32'h0);
    check(rd[0], 1'b1, "ping-pong switched to alternate");
    periph_req(0);
    check(done_cnt[0], 2, "ping-pong stops on invalid");
    // peripheral gather on channel 2, one task ending in basic
    set_desc(2, 0, 32'haa00_8036, 32'h211c, 32'h106c);
    set_desc(0, 32'h1110, 32'haa00_0001, 32'h2008, 32'h3408);
    periph_req(2);
    check(done_cnt[2], 1, "peripheral gather done");
    check(mem_u.mem[30'h418], 32'h2008, "alternate loaded");
    check(mem_u.mem[30'hd02], src[2], "peripheral gather data");
    // memory gather on channel 3, one task ending in autorequest
    set_desc(3, 0, 32'haa00_8034, 32'h210c, 32'h107c);
    set_desc(0, 32'h1100, 32'haa00_0012, 32'h2004, 32'h3404);
    data_wr = 0;
    wb(1'b1, REG_SWREQ, 32'h8);
    n = 0;
    while (done_cnt[3] == 0) begin
      if (++n > 3000) timeout("memory gather");
      @(posedge clk_i);
    end
    check(data_wr, 2, "memory gather alternate transfers");
    check(mem_u.mem[30'hd01], src[1], "memory gather data");
    check(mem_u.mem[30'h41e], 32'haa00_0000, "alternate finished invalid");
    wb(1'b0, REG_SWREQ, 32'h0);
    check(rd, 32'h0, "request register reads zero");
    report_and_stop();
  end
endmodule
